// ### src/obcl_regs.vh
// register offsets, option bit positions, reset values and delay counts of the option loader
`ifndef OBCL_REGS_VH
`define OBCL_REGS_VH

// ********************************************************
// apb register map (byte addresses)
// ********************************************************
`define OBCL_ADDR_OPT 8'h00
`define OBCL_ADDR_STAT 8'h04
`define OBCL_ADDR_W 8

// ********************************************************
// option word bit positions
// ********************************************************
`define OBCL_OPT_W 16
`define OBCL_BIT_OSC_GUARD 0
`define OBCL_BIT_OSC_RC 1
`define OBCL_BIT_LONG_DLY 2
`define OBCL_BIT_WDOG_HW 3
`define OBCL_BIT_PB_LO_OFF 4
`define OBCL_BIT_PB_HI_OFF 5
`define OBCL_BIT_EXT_STOP 6
`define OBCL_BIT_RD_LOCK 7
`define OBCL_BIT_LOWVOLT 8
`define OBCL_BIT_NMI_PULL 9
`define OBCL_BIT_CONV_WAIT 12

// ********************************************************
// status register bit positions
// ********************************************************
`define OBCL_STAT_PROG 0
`define OBCL_STAT_RUN 1
`define OBCL_STAT_DLY 2

// ********************************************************
// reset values
// ********************************************************
// blank store content: reserved bit 11 set, all options off
`define OBCL_NV_BLANK 16'h0800

// ********************************************************
// post-reset delay in oscillator cycles; clk is the oscillator
// ********************************************************
`define OBCL_DLY_SHORT_OSC 2048
`define OBCL_DLY_LONG_OSC 32768
`define OBCL_DLY_SHORT_CYC (`OBCL_DLY_SHORT_OSC * 1)
`define OBCL_DLY_LONG_CYC (`OBCL_DLY_LONG_OSC * 1)
`define OBCL_DLY_CNT_W 16

`endif

// ### src/obcl_sync.v
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module obcl_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
)(
  input wire clk,
  input wire reset_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  // first stage, read only by the second stage
  reg [W-1:0] meta_r;

  // ********************************************************
  // synchroniser stages
  // ********************************************************
  // reset to the idle level of each pin
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ### src/obcl_dly.v
// post-reset delay counter with short and long length
`timescale 1ns/1ps
`include "obcl_regs.vh"
module obcl_dly #(
  parameter SHORT_CYC = `OBCL_DLY_SHORT_CYC,
  parameter LONG_CYC = `OBCL_DLY_LONG_CYC
)(
  input wire clk,
  input wire reset_n,
  input wire clear,
  input wire sel_long,
  output reg done
);
  // terminal counts, cut to the counter width on purpose
  localparam integer SHORT_M1 = SHORT_CYC - 1;
  localparam integer LONG_M1 = LONG_CYC - 1;
  localparam [`OBCL_DLY_CNT_W-1:0] SHORT_LAST = SHORT_M1[`OBCL_DLY_CNT_W-1:0];
  localparam [`OBCL_DLY_CNT_W-1:0] LONG_LAST = LONG_M1[`OBCL_DLY_CNT_W-1:0];

  // elapsed cycles since clear fell
  reg [`OBCL_DLY_CNT_W-1:0] cnt_r;
  // terminal count for the selected length
  wire [`OBCL_DLY_CNT_W-1:0] last = sel_long ? LONG_LAST : SHORT_LAST;

  // ********************************************************
  // counter
  // ********************************************************
  // done rises at the n-th edge after clear is released, then holds
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r <= {`OBCL_DLY_CNT_W{1'b0}};
      done <= 1'b0;
    end
    else if (clear)
    begin
      cnt_r <= {`OBCL_DLY_CNT_W{1'b0}};
      done <= 1'b0;
    end
    else if (!done)
    begin
      if (cnt_r == last)
        done <= 1'b1;
      else
        cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule

// ### src/obcl_top.v
// option byte loader: non-volatile option word, reset-time load, decoded configuration
`timescale 1ns/1ps
`include "obcl_regs.vh"
module obcl_top #(
  parameter DLY_SHORT = `OBCL_DLY_SHORT_CYC,
  parameter DLY_LONG = `OBCL_DLY_LONG_CYC,
  parameter [`OBCL_OPT_W-1:0] NV_INIT = `OBCL_NV_BLANK
)(
  input wire clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`OBCL_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire ext_reset_n_pin,
  input wire prog_mode_pin,
  input wire lowvolt_det,
  input wire nmi_pin,
  input wire wdog_reset,
  input wire wdog_sw_enable,
  input wire stop_exec,
  input wire wait_exec,
  input wire wake_irq,
  input wire conv_start_bit,
  output reg core_reset_n,
  output reg cpu_run,
  output reg prog_mode,
  output reg readout_lock,
  output reg ext_stop_ctl,
  output reg portb_hi_pullup_off,
  output reg portb_lo_pullup_off,
  output reg [3:0] portb_reset_pullup,
  output reg wdog_hw_activate,
  output reg wdog_enable,
  output reg long_delay_sel,
  output reg osc_type_rc,
  output reg osc_guard_en,
  output reg conv_on_wait,
  output reg nmi_pullup_en,
  output reg lowvolt_reset_en,
  output reg conv_start,
  output reg enter_stop,
  output reg enter_wait,
  output reg wdog_freeze
);

  // ********************************************************
  // state encoding
  // ********************************************************
  localparam [2:0] S_RST = 3'h1; // internal reset held, options loading
  localparam [2:0] S_DLY = 3'h2; // reset released, delay running
  localparam [2:0] S_RUN = 3'h4; // core running

  // ********************************************************
  // declarations
  // ********************************************************
  reg [`OBCL_OPT_W-1:0] nv_word_r; // models the non-volatile store
  reg [`OBCL_OPT_W-1:0] opt_r; // word latched at the last reset
  reg [2:0] state_r; // one-hot sequencer state
  reg [2:0] state_nxt; // next sequencer state
  reg stop_active_r; // core sits in stop mode
  reg wdog_sw_on_r; // software has started the watchdog
  wire ext_rst_n_s; // synchronised reset pin
  wire prog_pin_s; // synchronised test pin level
  wire lowvolt_s; // synchronised low supply detector
  wire nmi_s; // synchronised nmi pin
  wire int_reset; // any source of internal reset
  wire dly_done; // post-reset delay elapsed
  wire apb_setup; // first cycle of an apb transfer
  wire apb_access; // completing cycle of an apb transfer
  wire hit_opt; // address decodes to the option word
  wire hit_stat; // address decodes to the status word
  wire opt_denied; // option access outside programming mode
  wire wdog_running; // watchdog counting in either mode

  // ********************************************************
  // pin synchronisers
  // ********************************************************
  // reset pin idles high, the other pins idle low
  obcl_sync #(
    .W(4),
    .RST_VAL(4'h8)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({ext_reset_n_pin, prog_mode_pin, lowvolt_det, nmi_pin}),
    .q({ext_rst_n_s, prog_pin_s, lowvolt_s, nmi_s})
  );
  // ********************************************************
  // reset sources
  // ********************************************************
  // low supply only counts once its option has been latched as enabled;
  // the enable comes from the previous load, so a word just programmed
  // takes effect only after the next reset
  assign int_reset = !ext_rst_n_s | wdog_reset | (lowvolt_s & lowvolt_reset_en);
  // ********************************************************
  // post-reset delay
  // ********************************************************
  // the counter is held clear for as long as reset is present
  obcl_dly #(
    .SHORT_CYC(DLY_SHORT),
    .LONG_CYC(DLY_LONG)
  ) u_dly (
    .clk(clk),
    .reset_n(reset_n),
    .clear(!state_r[1]),
    .sel_long(long_delay_sel),
    .done(dly_done)
  );
  // ********************************************************
  // sequencer next state
  // ********************************************************
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      // leave reset only when every source has gone away
      S_RST:
        if (!int_reset)
          state_nxt = S_DLY;
      S_DLY:
        if (int_reset)
          state_nxt = S_RST;
        else if (dly_done)
          state_nxt = S_RUN;
      S_RUN:
        if (int_reset)
          state_nxt = S_RST;
      default:
        state_nxt = S_RST;
    endcase
  end
  // ********************************************************
  // sequencer state and core control
  // ********************************************************
  // programming mode keeps the core stopped so that user code never runs
  // while the programmer owns the option word
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= S_RST;
      core_reset_n <= 1'b0;
      cpu_run <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      core_reset_n <= (state_nxt == S_RUN) && !prog_mode;
      cpu_run <= (state_nxt == S_RUN) && !prog_mode;
    end
  end
  // ********************************************************
  // option load at reset
  // ********************************************************
  // the word is copied on every cycle of reset and frozen afterwards; the
  // test pin level is caught the same way, never under the async reset
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      opt_r <= `OBCL_NV_BLANK;
      prog_mode <= 1'b0;
    end
    else if (state_r == S_RST)
    begin
      opt_r <= nv_word_r;
      prog_mode <= prog_pin_s;
    end
  end
  // ********************************************************
  // decoded configuration
  // ********************************************************
  // all fields come straight from the frozen copy, so they cannot move
  // between resets even if the store is rewritten
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      readout_lock <= 1'b0;
      ext_stop_ctl <= 1'b0;
      portb_hi_pullup_off <= 1'b0;
      portb_lo_pullup_off <= 1'b0;
      portb_reset_pullup <= 4'hf;
      wdog_hw_activate <= 1'b0;
      long_delay_sel <= 1'b0;
      osc_type_rc <= 1'b0;
      osc_guard_en <= 1'b0;
      conv_on_wait <= 1'b0;
      nmi_pullup_en <= 1'b0;
      lowvolt_reset_en <= 1'b0;
    end
    else
    begin
      readout_lock <= opt_r[`OBCL_BIT_RD_LOCK];
      ext_stop_ctl <= opt_r[`OBCL_BIT_EXT_STOP];
      portb_hi_pullup_off <= opt_r[`OBCL_BIT_PB_HI_OFF];
      portb_lo_pullup_off <= opt_r[`OBCL_BIT_PB_LO_OFF];
      // pull-up request per line 3..0 while reset is applied
      portb_reset_pullup <= {{2{!opt_r[`OBCL_BIT_PB_HI_OFF]}}, {2{!opt_r[`OBCL_BIT_PB_LO_OFF]}}};
      wdog_hw_activate <= opt_r[`OBCL_BIT_WDOG_HW];
      long_delay_sel <= opt_r[`OBCL_BIT_LONG_DLY];
      osc_type_rc <= opt_r[`OBCL_BIT_OSC_RC];
      osc_guard_en <= opt_r[`OBCL_BIT_OSC_GUARD];
      conv_on_wait <= opt_r[`OBCL_BIT_CONV_WAIT];
      nmi_pullup_en <= opt_r[`OBCL_BIT_NMI_PULL];
      lowvolt_reset_en <= opt_r[`OBCL_BIT_LOWVOLT];
    end
  end
  // ********************************************************
  // watchdog enable
  // ********************************************************
  // software start is sticky until reset; hardware mode needs no start
  assign wdog_running = wdog_hw_activate | wdog_sw_on_r;
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wdog_sw_on_r <= 1'b0;
      wdog_enable <= 1'b0;
    end
    else if (state_r == S_RST)
    begin
      wdog_sw_on_r <= 1'b0;
      wdog_enable <= 1'b0;
    end
    else
    begin
      if (wdog_sw_enable)
        wdog_sw_on_r <= 1'b1;
      // no software path can clear the hardware-activated watchdog
      wdog_enable <= wdog_hw_activate | wdog_sw_on_r | wdog_sw_enable;
    end
  end
  // ********************************************************
  // stop, wait and conversion start
  // ********************************************************
  // a stop with the watchdog running becomes a wait unless external stop
  // control is on and nmi is high; a wake request outranks a new stop
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enter_stop <= 1'b0;
      enter_wait <= 1'b0;
      stop_active_r <= 1'b0;
      wdog_freeze <= 1'b0;
      conv_start <= 1'b0;
    end
    else if (!cpu_run)
    begin
      enter_stop <= 1'b0;
      enter_wait <= 1'b0;
      stop_active_r <= 1'b0;
      wdog_freeze <= 1'b0;
      conv_start <= 1'b0;
    end
    else
    begin
      enter_stop <= stop_exec && (!wdog_running || (ext_stop_ctl && nmi_s));
      enter_wait <= wait_exec || (stop_exec && wdog_running && !(ext_stop_ctl && nmi_s));
      if (wake_irq)
        stop_active_r <= 1'b0;
      else if (stop_exec && (!wdog_running || (ext_stop_ctl && nmi_s)))
        stop_active_r <= 1'b1;
      // counter frozen only for a real stop with the watchdog running
      wdog_freeze <= wdog_running && !wake_irq &&
        (stop_active_r || (stop_exec && ext_stop_ctl && nmi_s));
      // wait-synchronised starts quiet the supply during conversion
      conv_start <= conv_on_wait ? wait_exec : conv_start_bit;
    end
  end
  // ********************************************************
  // apb slave
  // ********************************************************
  // zero wait states; read data is registered in the setup cycle
  assign apb_setup = psel && !penable;
  assign apb_access = psel && penable;
  assign hit_opt = (paddr == `OBCL_ADDR_OPT);
  assign hit_stat = (paddr == `OBCL_ADDR_STAT);
  assign opt_denied = hit_opt && !prog_mode;
  assign pready = 1'b1;
  // unmapped addresses and denied option accesses both report an error
  assign pslverr = apb_access && ((!hit_opt && !hit_stat) || opt_denied || (hit_stat && pwrite));
  // read data, zero for writes and anything not readable, so that an old
  // option word is never read back after programming mode ends; prdata holds its value between transfers
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= 32'h0;
    else if (apb_setup)
    begin
      if (!pwrite && hit_opt && prog_mode)
        prdata <= {16'h0, nv_word_r};
      else if (!pwrite && hit_stat)
        prdata <= {29'h0, state_r[1], cpu_run, prog_mode};
      else
        prdata <= 32'h0;
    end
  end
  // ********************************************************
  // non-volatile option store
  // ********************************************************
  // reset_n stands for power-up, when the store shows its content; the
  // reserved bits are stored as written, keeping them is the programmer's job
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      nv_word_r <= NV_INIT;
    else if (apb_access && pwrite && hit_opt && prog_mode)
      nv_word_r <= pwdata[`OBCL_OPT_W-1:0];
  end
endmodule

// ### verification/obcl_prog.sv
// programmer model: drives the test pin and reset pin, builds legal option words
`timescale 1ns/1ps
module obcl_prog (
  input wire clk,
  output reg ext_reset_n_pin,
  output reg prog_mode_pin
);
  // ********
  // pin driving
  // ********
  // both pins idle in normal-run state
  initial
  begin
    ext_reset_n_pin = 1'b1;
    prog_mode_pin = 1'b0;
  end

  // reset pulse of n cycles; the test pin only moves while reset is held
  task pulse(input bit prog, input int n);
    int i;
    @(posedge clk);
    ext_reset_n_pin <= 1'b0;
    prog_mode_pin <= prog;
    for (i = 0; i < n; i++)
      @(posedge clk);
    ext_reset_n_pin <= 1'b1;
  endtask

  // reserved bits forced so the store never holds an illegal word
  function [15:0] legal(input [31:0] r);
    legal = (r[15:0] & 16'h13ff) | 16'h0800;
  endfunction
endmodule

// ### verification/obcl_top_chk.sv
// concurrent checks on the option loader top ports
`timescale 1ns/1ps
`include "obcl_regs.vh"
module obcl_top_chk #(
  parameter DLY_SHORT = 8,
  parameter DLY_LONG = 32
)(
  input wire clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire [`OBCL_ADDR_W-1:0] paddr,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire wdog_reset,
  input wire stop_exec,
  input wire wait_exec,
  input wire conv_start_bit,
  input wire core_reset_n,
  input wire cpu_run,
  input wire prog_mode,
  input wire readout_lock,
  input wire ext_stop_ctl,
  input wire portb_hi_pullup_off,
  input wire portb_lo_pullup_off,
  input wire [3:0] portb_reset_pullup,
  input wire wdog_hw_activate,
  input wire wdog_enable,
  input wire long_delay_sel,
  input wire osc_type_rc,
  input wire osc_guard_en,
  input wire conv_on_wait,
  input wire nmi_pullup_en,
  input wire lowvolt_reset_en,
  input wire conv_start,
  input wire enter_stop,
  input wire enter_wait
);
  // ********
  // helper logic
  // ********
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // all latched options in one vector
  wire [11:0] cfg = {readout_lock, ext_stop_ctl, portb_hi_pullup_off, portb_lo_pullup_off, wdog_hw_activate,
    long_delay_sel, osc_type_rc, osc_guard_en, conv_on_wait, nmi_pullup_en, lowvolt_reset_en, prog_mode};
  // cycles the core has been held; wide enough for the long delay
  reg [19:0] lo_cnt_r;
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
      lo_cnt_r <= 20'h0;
    else if (core_reset_n)
      lo_cnt_r <= 20'h0;
    else
      lo_cnt_r <= lo_cnt_r + 20'h1;

  // ********
  // assertions
  // ********
  a_cfg_frozen: assert property (cpu_run && $past(cpu_run) |-> $stable(cfg))
    else $error("config changed while running");
  a_pullup_map: assert property (portb_reset_pullup == {{2{!portb_hi_pullup_off}}, {2{!portb_lo_pullup_off}}})
    else $error("port b pull-up map wrong");
  a_hw_wdog_on: assert property (cpu_run && wdog_hw_activate |-> wdog_enable)
    else $error("hardware watchdog not enabled");
  a_conv_cause: assert property (cpu_run && (conv_on_wait ? wait_exec : conv_start_bit) |=> conv_start)
    else $error("conversion start missing");
  a_conv_quiet: assert property (!(cpu_run && (conv_on_wait ? wait_exec : conv_start_bit)) |=> !conv_start)
    else $error("spurious conversion start");
  a_stop_wait: assert property (cpu_run && stop_exec && wdog_enable && !ext_stop_ctl |=> enter_wait && !enter_stop)
    else $error("stop not turned into wait");
  a_stop_free: assert property (cpu_run && stop_exec && !wdog_enable |=> enter_stop)
    else $error("stop refused without watchdog");
  a_prog_hold: assert property (prog_mode |-> !cpu_run && !core_reset_n)
    else $error("core runs in programming mode");
  a_opt_refused: assert property (psel && penable && paddr == `OBCL_ADDR_OPT && !prog_mode |-> pslverr && prdata == 32'h0)
    else $error("option word reachable outside programming");
  a_wdog_reset: assert property (wdog_reset |-> ##[1:4] !cpu_run)
    else $error("watchdog reset ignored");
  a_delay_len: assert property ($rose(cpu_run) |-> lo_cnt_r >= (long_delay_sel ? DLY_LONG : DLY_SHORT))
    else $error("post-reset delay too short");
endmodule

bind obcl_top obcl_top_chk #(.DLY_SHORT(DLY_SHORT), .DLY_LONG(DLY_LONG)) u_obcl_top_chk (.*);

// ### verification/tb.sv
// self-checking bench for the option loader top
`timescale 1ns/1ps
module tb;
  localparam int DS = 8; // shortened short delay
  localparam int DL = 32; // shortened long delay
  reg clk, reset_n, psel, penable, pwrite, lowvolt_det, nmi_pin, wdog_reset, wdog_sw_enable;
  reg stop_exec, wait_exec, wake_irq, conv_start_bit;
  reg [7:0] paddr;
  reg [31:0] pwdata;
  wire [31:0] prdata;
  wire pready, pslverr, ext_reset_n_pin, prog_mode_pin, core_reset_n, cpu_run, prog_mode, readout_lock;
  wire ext_stop_ctl, portb_hi_pullup_off, portb_lo_pullup_off, wdog_hw_activate, wdog_enable, long_delay_sel;
  wire osc_type_rc, osc_guard_en, conv_on_wait, nmi_pullup_en, lowvolt_reset_en, conv_start, enter_stop;
  wire enter_wait, wdog_freeze;
  wire [3:0] portb_reset_pullup;
  int err_count, checks_done, seed, k;
  reg [15:0] w; // option word of this round
  logic [31:0] rd;
  logic er;
  // decoded options packed at their word positions
  wire [15:0] cfg_vec = {3'h0, conv_on_wait, 2'h0, nmi_pullup_en, lowvolt_reset_en, readout_lock, ext_stop_ctl,
    portb_hi_pullup_off, portb_lo_pullup_off, wdog_hw_activate, long_delay_sel, osc_type_rc, osc_guard_en};

  obcl_top #(.DLY_SHORT(DS), .DLY_LONG(DL)) u_obcl_top (.*);
  obcl_prog u_obcl_prog (.*);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ********
  // tasks
  // ********
  task wrap_up;
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits for pready, never a fixed count
  task apb(input bit wr, input [7:0] a, input [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      chk(0, 1);
      wrap_up;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // waits for the core to run and checks the elapsed cycles
  task run_chk(input int lo, input int hi);
    int n;
    n = 0;
    while (cpu_run !== 1'b1 && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    chk(n >= lo && n <= hi, 1);
    if (n >= 2000)
      wrap_up;
  endtask

  // random stop, wait, conversion and watchdog-start pulses against the model
  task ops(input [15:0] v);
    int j;
    bit wd, st;
    reg [31:0] r;
    wd = v[3];
    for (j = 0; j < 8; j++)
    begin
      r = $random(seed);
      @(posedge clk);
      nmi_pin <= r[0];
      repeat (3) @(posedge clk);
      st = !wd || (v[6] && r[0]);
      case (r[2:1])
        2'd0: stop_exec <= 1'b1;
        2'd1: wait_exec <= 1'b1;
        2'd2: conv_start_bit <= 1'b1;
        default: wdog_sw_enable <= 1'b1;
      endcase
      @(posedge clk);
      {stop_exec, wait_exec, conv_start_bit, wdog_sw_enable} <= 4'h0;
      @(negedge clk);
      chk(enter_stop, r[2:1] == 0 && st);
      chk(enter_wait, (r[2:1] == 0 && !st) || r[2:1] == 1);
      chk(conv_start, v[12] ? r[2:1] == 1 : r[2:1] == 2);
      chk(wdog_freeze, r[2:1] == 0 && st && wd);
      if (r[2:1] == 3)
        wd = 1'b1;
      @(posedge clk);
      wake_irq <= 1'b1;
      @(posedge clk);
      wake_irq <= 1'b0;
      @(negedge clk);
      chk(wdog_freeze, 0);
      chk(wdog_enable, wd);
    end
  endtask

  // ********
  // main sequence
  // ********
  initial
  begin
    seed = 33927;
    err_count = 0;
    checks_done = 0;
    reset_n = 1'b0;
    {psel, penable, pwrite, lowvolt_det, nmi_pin, wdog_reset, wdog_sw_enable} = 7'h0;
    {stop_exec, wait_exec, wake_irq, conv_start_bit} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    run_chk(DS, DS + 8);
    chk(cfg_vec, 16'h0000);
    apb(1'b0, 8'h00, 32'h0, rd, er);
    chk({er, rd[30:0]}, 32'h80000000);
    apb(1'b0, 8'h08, 32'h0, rd, er);
    chk(er, 1);
    apb(1'b1, 8'h04, 32'h0, rd, er);
    chk(er, 1);
    apb(1'b0, 8'h04, 32'h0, rd, er);
    chk(rd[1:0], 2'h2);
    for (k = 0; k < 6; k++)
    begin
      w = u_obcl_prog.legal($random(seed));
      w[2] = k[0];
      u_obcl_prog.pulse(1'b1, 4);
      repeat (6) @(posedge clk);
      apb(1'b1, 8'h00, {16'h0, w}, rd, er);
      chk(er, 0);
      apb(1'b0, 8'h00, 32'h0, rd, er);
      chk(rd, {16'h0, w});
      apb(1'b0, 8'h04, 32'h0, rd, er);
      chk(rd[1:0], 2'h1);
      u_obcl_prog.pulse(1'b0, 4);
      run_chk(w[2] ? DL : DS, (w[2] ? DL : DS) + 8);
      chk(cfg_vec, w & 16'h13ff);
      chk(portb_reset_pullup, {~w[5], ~w[5], ~w[4], ~w[4]});
      apb(1'b1, 8'h00, 32'h0, rd, er);
      chk(er, 1);
      ops(w);
      @(posedge clk);
      lowvolt_det <= 1'b1;
      repeat (6) @(negedge clk);
      chk(cpu_run, !w[8]);
      @(posedge clk);
      lowvolt_det <= 1'b0;
      run_chk(w[8] ? (w[2] ? DL : DS) : 0, w[8] ? (w[2] ? DL : DS) + 8 : 0);
      @(posedge clk);
      wdog_reset <= 1'b1;
      @(posedge clk);
      wdog_reset <= 1'b0;
      repeat (3) @(negedge clk);
      chk(cpu_run, 0);
      run_chk(0, (w[2] ? DL : DS) + 8);
      chk(cfg_vec, w & 16'h13ff);
    end
    wrap_up;
  end
endmodule
